// ### core/fan_ctl_regs.sv
// Fan slow-flag, drive-ratio and identity register bank with PWM fan drive
`timescale 1ns/1ps
`include "fan_ctl_defines.svh"

module fan_ctl_regs #(
    parameter logic [7:0]  MAKER_CODE   = 8'hA5,  // Arbitrary value
    parameter logic [1:0]  VARIANT_CODE = 2'h1,   // Arbitrary value
    parameter int unsigned STEP_CYCLES  = `PWM_STEP_CYCLES
) (
    input  wire logic                 MCLK,
    input  wire logic                 RESETN,
    input  wire fan_ctl_pkg::reg_req_s REG_REQ,
    input  wire logic [7:0]           SPEED_READING_ONE,
    input  wire logic [7:0]           SPEED_READING_TWO,
    input  wire logic                 ANALOG_TEMP_OPEN,
    input  wire logic [3:0]           ANALOG_DUTY_CODE,
    output logic [7:0]                REG_RDATA,
    output logic                      ALERT_N,
    output logic                      FAN_DRIVE_OUT
);

    localparam int STEP_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;

    logic [7:0]        config_ff;
    logic [3:0]        drive_ratio_ff;
    logic [7:0]        limit_ff    [2];
    logic [1:0]        slow_flag_ff;
    logic [1:0]        nxt_slow_flag;
    logic [1:0]        slow_now;
    logic [7:0]        reading     [2];
    logic              clear_req;
    logic [7:0]        status_val;
    logic [7:0]        nxt_rdata;
    logic [3:0]        active_code;
    logic [7:0]        high_steps;
    logic [STEP_W-1:0] step_cnt_ff;
    logic [7:0]        phase_ff;

    assign reading[0] = SPEED_READING_ONE;
    assign reading[1] = SPEED_READING_TWO;

    // Clear pulse: config write with the clear bit high
    assign clear_req = REG_REQ.wr && (REG_REQ.addr == `ADDR_CONFIG)
                       && REG_REQ.wdata[`CFG_SLOW_CLEAR_BIT];

    // Per-fan sticky slow flag; a detection in the clear cycle wins
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_fan
            assign slow_now[g] = reading[g] < limit_ff[g];
            assign nxt_slow_flag[g] = slow_now[g] | (slow_flag_ff[g] & ~clear_req);

            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    slow_flag_ff[g] <= 1'b0;
                end else begin
                    slow_flag_ff[g] <= nxt_slow_flag[g];
                end
            end

            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    limit_ff[g] <= `LIMIT_RST;
                end else if (REG_REQ.wr &&
                             (REG_REQ.addr == ((g == 0) ? `ADDR_LIMIT_ONE : `ADDR_LIMIT_TWO))) begin
                    limit_ff[g] <= REG_REQ.wdata;
                end
            end
        end
    endgenerate

    // Alert follows the next flag value so it drops in the same edge as the flag
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ALERT_N <= 1'b1;
        end else begin
            ALERT_N <= ~(|nxt_slow_flag);
        end
    end

    // Clear bit is a strobe and is never stored, so it reads back zero
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            config_ff <= `CONFIG_RST;
        end else if (REG_REQ.wr && (REG_REQ.addr == `ADDR_CONFIG)) begin
            config_ff <= REG_REQ.wdata & ~(8'h01 << `CFG_SLOW_CLEAR_BIT);
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            drive_ratio_ff <= `DRIVE_RATIO_RST;
        end else if (REG_REQ.wr && (REG_REQ.addr == `ADDR_DRIVE_RATIO)) begin
            drive_ratio_ff <= REG_REQ.wdata[3:0];
        end
    end

    always_comb begin
        status_val = 8'h00;
        status_val[`ST_FAN_ONE_BIT]     = slow_flag_ff[0];
        status_val[`ST_FAN_TWO_BIT]     = slow_flag_ff[1];
        status_val[`ST_ANALOG_OPEN_BIT] = ANALOG_TEMP_OPEN;
    end

    // Identity registers have no write path at all
    always_comb begin
        case (REG_REQ.addr)
            `ADDR_CONFIG:      nxt_rdata = config_ff;
            `ADDR_FAN_STATUS:  nxt_rdata = status_val;
            `ADDR_DRIVE_RATIO: nxt_rdata = {4'h0, drive_ratio_ff};
            `ADDR_LIMIT_ONE:   nxt_rdata = limit_ff[0];
            `ADDR_LIMIT_TWO:   nxt_rdata = limit_ff[1];
            `ADDR_MAKER_ID:    nxt_rdata = MAKER_CODE;
            `ADDR_VARIANT_ID:  nxt_rdata = {6'h00, VARIANT_CODE};
            default:           nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_REQ.rd) begin
            REG_RDATA <= nxt_rdata;
        end
    end

    // Duty source: bus register, analog code, or default code when the input floats
    always_comb begin
        if (config_ff[`CFG_BUS_DUTY_BIT]) begin
            active_code = drive_ratio_ff;
        end else if (ANALOG_TEMP_OPEN) begin
            active_code = `ANALOG_OPEN_CODE;
        end else begin
            active_code = ANALOG_DUTY_CODE;
        end
    end

    // 45 + 7n of 150 steps: exact 30 % to 100 % with 4.67 % per code
    assign high_steps = `PWM_BASE_STEPS
                        + 8'(`PWM_STEP_PER_CODE * {4'h0, active_code});

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            step_cnt_ff <= '0;
        end else if (step_cnt_ff == STEP_W'(STEP_CYCLES - 1)) begin
            step_cnt_ff <= '0;
        end else begin
            step_cnt_ff <= step_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_ff <= 8'h00;
        end else if (step_cnt_ff == STEP_W'(STEP_CYCLES - 1)) begin
            phase_ff <= (phase_ff == `PWM_STEPS - 8'h01) ? 8'h00 : phase_ff + 8'h01;
        end
    end

    // Code changes take effect at once; a glitchy period is harmless to a fan
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            FAN_DRIVE_OUT <= 1'b0;
        end else begin
            FAN_DRIVE_OUT <= phase_ff < high_steps;
        end
    end

endmodule

// ### core/fan_ctl_defines.svh
// Register offsets, field positions, reset values and timing counts of the fan controller
// Operation
// - Fan-two slow flag (status bit 1) is set whenever speed_reading_two is below speed_limit_two.
// - The active-low alert output goes low together with either slow flag being set.
// - A set slow flag is cleared only by the host writing slow_flag_clear (config bit 7).
// - After reset both slow flags read zero until a low-speed condition is seen.
// - Fan-one slow flag (status bit 0) is set when the fan-one reading is below its limit.
// - A four-bit read/write drive_ratio register sets the duty of the fan drive output.
// - Duty spans 30 to 100 percent over sixteen codes, in fifteen equal steps of about 4.67 percent.
// - Code n gives 30 + 4.67*n percent, 0000 at 30, 1110 at 95.33 and 1111 at 100.
// - With analog control selected and the analog input open, the drive uses code 0010.
// - maker_identity is an eight-bit read-only fixed code; writes do nothing.
// - variant_identity is a two-bit read-only fixed code naming the device variant.
`ifndef FAN_CTL_DEFINES_SVH
`define FAN_CTL_DEFINES_SVH

`define ADDR_CONFIG        8'h00
`define ADDR_FAN_STATUS    8'h01
`define ADDR_DRIVE_RATIO   8'h02
`define ADDR_LIMIT_ONE     8'h03
`define ADDR_LIMIT_TWO     8'h04
`define ADDR_MAKER_ID      8'h05
`define ADDR_VARIANT_ID    8'h06

`define CFG_SLOW_CLEAR_BIT 7
`define CFG_BUS_DUTY_BIT   5
`define ST_FAN_ONE_BIT     0
`define ST_FAN_TWO_BIT     1
`define ST_ANALOG_OPEN_BIT 2

`define DRIVE_RATIO_RST    4'h2
`define ANALOG_OPEN_CODE   4'h2
`define LIMIT_RST          8'h00
`define CONFIG_RST         8'h00

// Duty in 1/150 of a period: 45/150 = 30 %, 7/150 = 4.67 % per code
`define PWM_STEPS          8'h96
`define PWM_BASE_STEPS     8'h2D
`define PWM_STEP_PER_CODE  8'h07

`define CLK_MHZ            40
`define PWM_PERIOD_US      33333
`define PWM_STEP_CYCLES    ((`PWM_PERIOD_US * `CLK_MHZ) / 150)

`endif

// ### core/fan_ctl_pkg.sv
// Types shared by the fan controller register bank
package fan_ctl_pkg;

    // One register access from the two-wire bus engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef logic [7:0] byte_t;

endpackage

// ### sim/fan_ctl_assertions.sv
// Checker for slow flags, alert and register reads
`timescale 1ns/1ps
module fan_ctl_assertions #(
    parameter logic [7:0]  MAKER_CODE   = 8'hA5,
    parameter logic [1:0]  VARIANT_CODE = 2'h1,
    parameter int unsigned STEP_CYCLES  = 1
) (
    input wire logic                  MCLK,
    input wire logic                  RESETN,
    input wire fan_ctl_pkg::reg_req_s REG_REQ,
    input wire logic [7:0]            SPEED_READING_ONE,
    input wire logic [7:0]            SPEED_READING_TWO,
    input wire logic                  ANALOG_TEMP_OPEN,
    input wire logic [3:0]            ANALOG_DUTY_CODE,
    input wire logic [7:0]            REG_RDATA,
    input wire logic                  ALERT_N,
    input wire logic                  FAN_DRIVE_OUT
);
    logic [7:0] lim1_ff;
    logic [7:0] lim2_ff;
    logic       slow_ff;
    logic       clr;
    logic       slow;
    assign clr  = REG_REQ.wr && REG_REQ.addr == 8'h00 && REG_REQ.wdata[7];
    assign slow = SPEED_READING_ONE < lim1_ff || SPEED_READING_TWO < lim2_ff;
    // Shadow copies of the limits, tracked from the register port
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            lim1_ff <= 8'h00;
            lim2_ff <= 8'h00;
        end else if (REG_REQ.wr) begin
            if (REG_REQ.addr == 8'h03) lim1_ff <= REG_REQ.wdata;
            if (REG_REQ.addr == 8'h04) lim2_ff <= REG_REQ.wdata;
        end
    end
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) slow_ff <= 1'b0;
        else slow_ff <= slow;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_fan_two_set: assert property (SPEED_READING_TWO < lim2_ff |=> !ALERT_N)
        else $error("fan two slow did not assert alert");
    a_fan_one_set: assert property (SPEED_READING_ONE < lim1_ff |=> !ALERT_N)
        else $error("fan one slow did not assert alert");
    a_alert_cause: assert property ($fell(ALERT_N) |-> slow_ff)
        else $error("alert fell with no slow fan");
    a_alert_sticky: assert property (!ALERT_N && !clr |=> !ALERT_N)
        else $error("alert released without clear");
    a_clear_alert: assert property (clr && !slow |=> ALERT_N)
        else $error("clear did not release alert");
    a_reset_idle: assert property ($rose(RESETN) |-> ALERT_N)
        else $error("alert low after reset");
    a_maker_read: assert property (REG_REQ.rd && REG_REQ.addr == 8'h05
        |=> REG_RDATA == MAKER_CODE)
        else $error("maker code read wrong");
    a_variant_read: assert property (REG_REQ.rd && REG_REQ.addr == 8'h06
        |=> REG_RDATA == {6'h00, VARIANT_CODE})
        else $error("variant code read wrong");
    a_ratio_width: assert property (REG_REQ.rd && REG_REQ.addr == 8'h02
        |=> REG_RDATA[7:4] == 4'h0)
        else $error("drive ratio upper nibble set");
    a_rdata_hold: assert property (!REG_REQ.rd |=> $stable(REG_RDATA))
        else $error("read data changed without read");
    c_alert: cover property ($fell(ALERT_N));
    c_clear: cover property (clr ##1 ALERT_N);
    c_maker: cover property (REG_REQ.rd && REG_REQ.addr == 8'h05);
endmodule
bind fan_ctl_regs fan_ctl_assertions #(.MAKER_CODE(MAKER_CODE), .VARIANT_CODE(VARIANT_CODE),
    .STEP_CYCLES(STEP_CYCLES)) u_chk (.MCLK(MCLK), .RESETN(RESETN), .REG_REQ(REG_REQ),
    .SPEED_READING_ONE(SPEED_READING_ONE), .SPEED_READING_TWO(SPEED_READING_TWO),
    .ANALOG_TEMP_OPEN(ANALOG_TEMP_OPEN), .ANALOG_DUTY_CODE(ANALOG_DUTY_CODE),
    .REG_RDATA(REG_RDATA), .ALERT_N(ALERT_N), .FAN_DRIVE_OUT(FAN_DRIVE_OUT));

// ### sim/bus_host.sv
// Bus host model issuing single register reads and writes
`timescale 1ns/1ps
module bus_host (
    input  wire logic            mclk,
    input  wire logic [7:0]      rdata,
    output fan_ctl_pkg::reg_req_s req
);
    initial req = '0;
    // Two idle cycles between requests keep every request whole
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge mclk);
        req <= {w, !w, a, d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
        q = rdata;
    endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the fan controller register bank
`timescale 1ns/1ps
module tb_top;
    logic                  mclk = 1'b0;
    logic                  resetn = 1'b0;
    logic [7:0]            sp1 = 8'h80;
    logic [7:0]            sp2 = 8'h80;
    logic                  aopen = 1'b0;
    logic [3:0]            acode = 4'h0;
    logic [7:0]            rdata;
    logic                  alert_n;
    logic                  fan_out;
    logic [7:0]            q;
    fan_ctl_pkg::reg_req_s req;
    int                    n_mismatch = 0;
    int                    n_checks = 0;
    always #12.5 mclk = ~mclk;
    // Identity values are arbitrary
    fan_ctl_regs #(.MAKER_CODE(8'h3C), .VARIANT_CODE(2'h2), .STEP_CYCLES(1)) dut (
        .MCLK(mclk), .RESETN(resetn), .REG_REQ(req), .SPEED_READING_ONE(sp1),
        .SPEED_READING_TWO(sp2), .ANALOG_TEMP_OPEN(aopen), .ANALOG_DUTY_CODE(acode),
        .REG_RDATA(rdata), .ALERT_N(alert_n), .FAN_DRIVE_OUT(fan_out));
    bus_host h (.mclk(mclk), .rdata(rdata), .req(req));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.access(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        h.access(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    // Any 150 consecutive samples span exactly one period
    task automatic duty_chk(input logic [7:0] exp);
        int hi;
        hi = 0;
        repeat (150) @(posedge mclk);
        repeat (150) begin
            @(posedge mclk);
            hi += fan_out;
        end
        check(8'(hi), exp);
    endtask
    task automatic t_reset();
        rd_chk(8'h01, 8'h00);
        check({7'h00, alert_n}, 8'h01);
        rd_chk(8'h02, 8'h02);
    endtask
    task automatic t_ident();
        wr(8'h05, 8'hFF);
        rd_chk(8'h05, 8'h3C);
        wr(8'h06, 8'h00);
        rd_chk(8'h06, 8'h02);
        rd_chk(8'h7F, 8'h00);
    endtask
    task automatic t_flags();
        wr(8'h03, 8'h40);
        wr(8'h04, 8'h40);
        @(posedge mclk) sp2 <= 8'h30;
        rd_chk(8'h01, 8'h02);
        check({7'h00, alert_n}, 8'h00);
        @(posedge mclk) sp2 <= 8'h80;
        rd_chk(8'h01, 8'h02);
        wr(8'h00, 8'h80);
        rd_chk(8'h01, 8'h00);
        check({7'h00, alert_n}, 8'h01);
        @(posedge mclk) sp1 <= 8'h10;
        rd_chk(8'h01, 8'h01);
        wr(8'h00, 8'h80);
        rd_chk(8'h01, 8'h01);
        check({7'h00, alert_n}, 8'h00);
        @(posedge mclk) sp1 <= 8'h80;
        wr(8'h00, 8'h80);
        rd_chk(8'h01, 8'h00);
    endtask
    task automatic t_duty();
        logic [3:0] codes[4];
        codes = '{4'h0, 4'h1, 4'hE, 4'hF};
        wr(8'h02, 8'h1F);
        rd_chk(8'h02, 8'h0F);
        wr(8'h00, 8'h20);
        for (int i = 0; i < 4; i++) begin
            wr(8'h02, {4'h0, codes[i]});
            duty_chk(8'h2D + 8'h07 * {4'h0, codes[i]});
        end
        wr(8'h00, 8'h00);
        @(posedge mclk) begin
            aopen <= 1'b1;
            acode <= 4'hF;
        end
        duty_chk(8'h3B);
        rd_chk(8'h01, 8'h04);
        @(posedge mclk) aopen <= 1'b0;
        duty_chk(8'h96);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_ident();
        t_flags();
        t_duty();
        print_verdict();
    end
endmodule
